// ==== design/mcfg_pkg.sv ====
// Purpose: Shared constants of the monitor configuration register group.
// Assumes: Register indices are word indices on the Avalon-MM slave.
// Notes: Ramp slot timing derives from the 25 MHz clock.
package mcfg_pkg;
  // Register word indices.
  localparam logic [7:0] CONV_CTRL_IDX = 8'h16;
  localparam logic [7:0] DIV_A_IDX = 8'h18;
  localparam logic [7:0] DIV_B_IDX = 8'h19;
  localparam logic [7:0] RAMP_CTRL_IDX = 8'h1a;
  localparam logic [7:0] GRP_CTRL_IDX = 8'h40;
  localparam logic [7:0] GRP_STAT_IDX = 8'h41;

  // Power-on values.
  localparam logic [7:0] CONV_CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_A_RST = 8'hff;
  localparam logic [7:0] DIV_B_RST = 8'h37;
  localparam logic [7:0] RAMP_CTRL_RST = 8'h00;

  // Field positions of the conversion channel control register.
  localparam int AUX_A_BIT = 0;
  localparam int AUX_B_BIT = 1;
  localparam int SINGLE_BIT = 2;
  localparam int CH_SEL_LSB = 3;
  localparam int CH_SEL_W = 5;

  // Channel codes named in the select field.
  localparam logic [4:0] CH_PIN26 = 5'h00;
  localparam logic [4:0] CH_REMOTE1 = 5'h01;
  localparam logic [4:0] CH_V3P3 = 5'h08;
  localparam logic [4:0] CH_V1P5_A = 5'h10;
  localparam logic [4:0] CH_V1P5_B = 5'h11;
  localparam logic [4:0] CH_LAST = CH_V1P5_B;

  // Divider register layout; bit 0 of the first register is fixed.
  localparam logic DIV_A_FIXED_BIT = 1'b1;
  localparam logic [7:0] DIV_B_PIN_MASK = 8'h37;

  // Fan ramp control layout.
  localparam int RAMP_EN_LSB = 0;
  localparam int RATE1_LSB = 2;
  localparam int RATE2_LSB = 5;
  localparam int RATE_W = 3;
  localparam int NUM_RAMP = 2;

  // Duty increase per slot for each rate code.
  localparam logic [7:0] RAMP_STEP [8] = '{8'h01, 8'h02, 8'h03, 8'h05,
                                           8'h08, 8'h0c, 8'h18, 8'h30};

  // Group control register bits.
  localparam int LOCK_BIT = 0;
  localparam int SOFT_RST_BIT = 1;
  localparam int VIOL_CLR_BIT = 2;
  // Group status register fields.
  localparam int STAT_CH_LSB = 0;
  localparam int STAT_DUTY1_LSB = 8;
  localparam int STAT_DUTY2_LSB = 16;
  localparam int STAT_LOCK_BIT = 24;
  localparam int STAT_VIOL_BIT = 25;

  // Ramp slot timing.
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RAMP_SLOT_US = 205_000;
  localparam int unsigned RAMP_SLOT_CYC = (RAMP_SLOT_US / 1000) * (CLK_HZ / 1000);
endpackage

// ==== design/mcfg_ramp.sv ====
// Purpose: Gradual duty ramp for one fan drive output.
// Assumes: slot_tick_i is a one-cycle pulse per time slot.
// Notes: With the ramp off the duty follows the target at once.
`timescale 1ns/1ps
module mcfg_ramp (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control.
  input wire logic enable_i,
  input wire logic [2:0] rate_i,
  input wire logic slot_tick_i,
  input wire logic [7:0] target_i,
  // Result.
  output logic [7:0] duty_o
);
  logic [7:0] duty_r;
  logic [7:0] duty_nxt;
  wire [7:0] step_w = mcfg_pkg::RAMP_STEP[rate_i];
  wire up_w = target_i > duty_r;
  wire [7:0] gap_w = up_w ? 8'(target_i - duty_r) : 8'(duty_r - target_i);

  always_comb begin
    duty_nxt = duty_r;
    if (!enable_i) begin
      duty_nxt = target_i;
    end else if (slot_tick_i && gap_w != 8'h00) begin
      if (gap_w <= step_w) begin
        duty_nxt = target_i;
      end else if (up_w) begin
        duty_nxt = 8'(duty_r + step_w);
      end else begin
        duty_nxt = 8'(duty_r - step_w);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      duty_r <= 8'h00;
    end else begin
      duty_r <= duty_nxt;
    end
  end

  assign duty_o = duty_r;
endmodule

// ==== design/mcfg_chan_seq.sv ====
// Purpose: Picks the channel the converter measures next.
// Assumes: conv_done_i pulses once when a conversion ends.
// Notes: Round-robin walks codes 0x00 to the last listed code.
`timescale 1ns/1ps
module mcfg_chan_seq (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control.
  input wire logic single_i,
  input wire logic [4:0] sel_i,
  input wire logic conv_done_i,
  // Result.
  output logic [4:0] chan_o
);
  logic [4:0] chan_r;
  wire [4:0] next_rr_w = (chan_r >= mcfg_pkg::CH_LAST) ? mcfg_pkg::CH_PIN26 : 5'(chan_r + 5'h01);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan_r <= mcfg_pkg::CH_PIN26;
    end else if (single_i) begin
      chan_r <= sel_i;
    end else if (conv_done_i) begin
      chan_r <= next_rr_w;
    end
  end

  assign chan_o = chan_r;
endmodule

// ==== design/mcfg_top.sv ====
// Purpose: Configuration register group of a system monitor on Avalon-MM.
// Assumes: Word-addressed slave; each register except the status word in lane 0 of its word.
// Notes: Every access takes one wait cycle before completing.
// Functional notes
// - Bit 0 of channel control enables aux output on general pin 5; off at reset.
// - Bit 1 of channel control enables aux output on general pin 6; off at reset.
// - Bit 2 set forces conversions onto one fixed channel; resets to 0.
// - The fixed channel is the one in the channel select field.
// - Select field bits 7:3 encode the channel; 00000 selects pin 26 by default.
// - Clearing bits 1..7 of divider register A removes that pin's divider; reset all on.
// - Bit 0 of divider register A is reserved and read-only.
// - Clearing bits 0,1,2,4,5 of divider register B removes that divider; reset on.
// - Bits 3, 7 and 6 of divider register B are writable storage resetting to 0.
// - The four configuration registers are lockable and return to defaults on software reset; the lock bit holds until power-on reset.
// - Fan ramp register bits 0 and 1 enable ramping for fan drives 1 and 2.
// - Bits 4:2 select fan 1 step: 1,2,3,5,8,12,24,48; reset 000.
// - Bits 7:5 select fan 2 step with the same encoding; reset 000.
// - Rates give 33 to 100 percent in about 35 s down to 0.8 s.
`timescale 1ns/1ps
module mcfg_top #(
  parameter int unsigned SLOT_CYCLES = mcfg_pkg::RAMP_SLOT_CYC
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Converter interface.
  input wire logic conv_done_i,
  output logic [4:0] conv_channel_o,
  output logic single_channel_o,
  // Pin functions.
  output logic aux_output_enable_a_o,
  output logic aux_output_enable_b_o,
  output logic [6:0] divider_enable_a_o,
  output logic [7:0] divider_enable_b_o,
  // Fan drives.
  input wire logic [7:0] fan_drive_1_target_i,
  input wire logic [7:0] fan_drive_2_target_i,
  output logic [7:0] fan_drive_1_duty_o,
  output logic [7:0] fan_drive_2_duty_o
);
  // Register storage.
  logic [7:0] conv_ctrl_r;
  logic [7:1] div_a_r;
  logic [7:0] div_b_r;
  logic [7:0] ramp_ctrl_r;
  logic lock_r;
  logic viol_r;
  logic aux_a_r;
  logic aux_b_r;
  logic single_r;

  // Bus handshake state.
  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;

  // Ramp slot timer.
  logic [31:0] slot_cnt_r;
  logic slot_tick_r;

  // Address decode.
  wire hit_conv_w = avs_address_i == mcfg_pkg::CONV_CTRL_IDX;
  wire hit_div_a_w = avs_address_i == mcfg_pkg::DIV_A_IDX;
  wire hit_div_b_w = avs_address_i == mcfg_pkg::DIV_B_IDX;
  wire hit_ramp_w = avs_address_i == mcfg_pkg::RAMP_CTRL_IDX;
  wire hit_gctl_w = avs_address_i == mcfg_pkg::GRP_CTRL_IDX;
  wire hit_stat_w = avs_address_i == mcfg_pkg::GRP_STAT_IDX;
  wire hit_cfg_w = hit_conv_w | hit_div_a_w | hit_div_b_w | hit_ramp_w;

  // A request is answered one cycle after it is first seen.
  wire req_w = avs_read_i | avs_write_i;
  wire commit_w = avs_write_i & ~wait_r & avs_byteenable_i[0];
  wire cfg_wr_w = commit_w & ~lock_r;
  wire [7:0] wd_w = avs_writedata_i[7:0];

  // Group control actions.
  wire gctl_wr_w = commit_w & hit_gctl_w;
  wire soft_rst_w = gctl_wr_w & wd_w[mcfg_pkg::SOFT_RST_BIT];
  wire lock_set_w = gctl_wr_w & wd_w[mcfg_pkg::LOCK_BIT];
  wire viol_set_w = commit_w & lock_r & hit_cfg_w;
  wire viol_clr_w = gctl_wr_w & wd_w[mcfg_pkg::VIOL_CLR_BIT];

  // Per-register write strobes.
  wire wr_conv_w = cfg_wr_w & hit_conv_w;
  wire wr_div_a_w = cfg_wr_w & hit_div_a_w;
  wire wr_div_b_w = cfg_wr_w & hit_div_b_w;
  wire wr_ramp_w = cfg_wr_w & hit_ramp_w;

  // Next values of the configuration registers.
  wire [7:0] conv_nxt_w = soft_rst_w ? mcfg_pkg::CONV_CTRL_RST :
                          wr_conv_w ? wd_w : conv_ctrl_r;
  wire [7:1] div_a_nxt_w = soft_rst_w ? mcfg_pkg::DIV_A_RST[7:1] :
                           wr_div_a_w ? wd_w[7:1] : div_a_r;
  wire [7:0] div_b_nxt_w = soft_rst_w ? mcfg_pkg::DIV_B_RST :
                           wr_div_b_w ? wd_w : div_b_r;
  wire [7:0] ramp_nxt_w = soft_rst_w ? mcfg_pkg::RAMP_CTRL_RST :
                          wr_ramp_w ? wd_w : ramp_ctrl_r;

  // Fields of the configuration registers.
  wire [4:0] ch_sel_w = conv_ctrl_r[mcfg_pkg::CH_SEL_LSB +: mcfg_pkg::CH_SEL_W];
  wire [1:0] ramp_en_w = ramp_ctrl_r[mcfg_pkg::RAMP_EN_LSB +: mcfg_pkg::NUM_RAMP];
  wire [2:0] rate_w [mcfg_pkg::NUM_RAMP];
  assign rate_w[0] = ramp_ctrl_r[mcfg_pkg::RATE1_LSB +: mcfg_pkg::RATE_W];
  assign rate_w[1] = ramp_ctrl_r[mcfg_pkg::RATE2_LSB +: mcfg_pkg::RATE_W];

  // Fan targets and results as arrays for the ramp loop.
  wire [7:0] target_w [mcfg_pkg::NUM_RAMP];
  wire [7:0] duty_w [mcfg_pkg::NUM_RAMP];
  assign target_w[0] = fan_drive_1_target_i;
  assign target_w[1] = fan_drive_2_target_i;

  // Status word shows live channel, duties, lock and violation.
  wire [4:0] chan_w;
  wire [31:0] stat_w = (32'(chan_w) << mcfg_pkg::STAT_CH_LSB) |
                       (32'(duty_w[0]) << mcfg_pkg::STAT_DUTY1_LSB) |
                       (32'(duty_w[1]) << mcfg_pkg::STAT_DUTY2_LSB) |
                       (32'(lock_r) << mcfg_pkg::STAT_LOCK_BIT) |
                       (32'(viol_r) << mcfg_pkg::STAT_VIOL_BIT);

  // Read selection; unmapped words read as zero.
  wire [7:0] div_a_rd_w = {div_a_r, mcfg_pkg::DIV_A_FIXED_BIT};
  wire [31:0] gctl_rd_w = 32'(lock_r) << mcfg_pkg::LOCK_BIT;
  wire [31:0] rd_mux_w = hit_conv_w ? {24'h000000, conv_ctrl_r} :
                         hit_div_a_w ? {24'h000000, div_a_rd_w} :
                         hit_div_b_w ? {24'h000000, div_b_r} :
                         hit_ramp_w ? {24'h000000, ramp_ctrl_r} :
                         hit_gctl_w ? gctl_rd_w :
                         hit_stat_w ? stat_w : 32'h00000000;

  // The slot timer wraps once per ramp slot.
  wire slot_end_w = slot_cnt_r >= 32'(SLOT_CYCLES - 1);
  wire [31:0] slot_cnt_nxt_w = slot_end_w ? 32'h00000000 : 32'(slot_cnt_r + 32'h00000001);

  always_comb begin
    wait_nxt = 1'b1;
    if (req_w && wait_r) begin
      wait_nxt = 1'b0;
    end
  end

  // Bus handshake and read data.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      wait_r <= wait_nxt;
      if (avs_read_i && wait_r) begin
        rdata_r <= rd_mux_w;
      end
    end
  end

  // Configuration registers with software reset.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_ctrl_r <= mcfg_pkg::CONV_CTRL_RST;
      div_a_r <= mcfg_pkg::DIV_A_RST[7:1];
      div_b_r <= mcfg_pkg::DIV_B_RST;
      ramp_ctrl_r <= mcfg_pkg::RAMP_CTRL_RST;
    end else begin
      conv_ctrl_r <= conv_nxt_w;
      div_a_r <= div_a_nxt_w;
      div_b_r <= div_b_nxt_w;
      ramp_ctrl_r <= ramp_nxt_w;
    end
  end

  // Lock holds until power-on reset; violation flag set wins over clear.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_r <= 1'b0;
      viol_r <= 1'b0;
    end else begin
      lock_r <= lock_r | lock_set_w;
      viol_r <= viol_set_w | (viol_r & ~viol_clr_w);
    end
  end

  // Pin function outputs follow their control bits.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_a_r <= 1'b0;
      aux_b_r <= 1'b0;
      single_r <= 1'b0;
    end else begin
      aux_a_r <= conv_ctrl_r[mcfg_pkg::AUX_A_BIT];
      aux_b_r <= conv_ctrl_r[mcfg_pkg::AUX_B_BIT];
      single_r <= conv_ctrl_r[mcfg_pkg::SINGLE_BIT];
    end
  end

  // Ramp slot timer.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_cnt_r <= 32'h00000000;
      slot_tick_r <= 1'b0;
    end else begin
      slot_cnt_r <= slot_cnt_nxt_w;
      slot_tick_r <= slot_end_w;
    end
  end

  // Channel sequencer.
  mcfg_chan_seq u_seq (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .single_i(single_r),
    .sel_i(ch_sel_w),
    .conv_done_i(conv_done_i),
    .chan_o(chan_w)
  );

  // One ramp engine per fan drive.
  genvar gi;
  generate
    for (gi = 0; gi < mcfg_pkg::NUM_RAMP; gi++) begin : g_ramp
      mcfg_ramp u_ramp (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .enable_i(ramp_en_w[gi]),
        .rate_i(rate_w[gi]),
        .slot_tick_i(slot_tick_r),
        .target_i(target_w[gi]),
        .duty_o(duty_w[gi])
      );
    end
  endgenerate

  // Outputs.
  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;
  assign conv_channel_o = chan_w;
  assign single_channel_o = single_r;
  assign aux_output_enable_a_o = aux_a_r;
  assign aux_output_enable_b_o = aux_b_r;
  assign divider_enable_a_o = div_a_r;
  assign divider_enable_b_o = div_b_r;
  assign fan_drive_1_duty_o = duty_w[0];
  assign fan_drive_2_duty_o = duty_w[1];
endmodule

// ==== testbench/mcfg_top_sva.sv ====
// Purpose: Port-level checks of the monitor configuration register group.
// Assumes: Lock state is rebuilt here from committed writes to the group control word.
// Notes: Attached to every mcfg_top instance by the bind after the module.
`timescale 1ns/1ps
module mcfg_top_sva #(
  parameter int unsigned SLOT_CYCLES = mcfg_pkg::RAMP_SLOT_CYC
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Converter and pin functions.
  input wire logic conv_done_i,
  input wire logic [4:0] conv_channel_o,
  input wire logic single_channel_o,
  input wire logic aux_output_enable_a_o,
  input wire logic aux_output_enable_b_o,
  input wire logic [6:0] divider_enable_a_o,
  input wire logic [7:0] divider_enable_b_o,
  // Fan drives.
  input wire logic [7:0] fan_drive_1_target_i,
  input wire logic [7:0] fan_drive_2_target_i,
  input wire logic [7:0] fan_drive_1_duty_o,
  input wire logic [7:0] fan_drive_2_duty_o
);
  logic locked_r;
  logic ramp_seen_r;
  logic [4:0] sel_r;
  wire wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  wire wr_open = wr_ok && !locked_r;
  wire wr16 = wr_open && (avs_address_i == mcfg_pkg::CONV_CTRL_IDX);
  wire wr18 = wr_open && (avs_address_i == mcfg_pkg::DIV_A_IDX);
  wire wr19 = wr_open && (avs_address_i == mcfg_pkg::DIV_B_IDX);
  wire wr18_locked = wr_ok && locked_r && (avs_address_i == mcfg_pkg::DIV_A_IDX);
  wire wr1a = wr_ok && (avs_address_i == mcfg_pkg::RAMP_CTRL_IDX);
  wire wr40 = wr_ok && (avs_address_i == mcfg_pkg::GRP_CTRL_IDX);

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Lock is sticky until power reset; ramp tracking stays set once touched.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      locked_r <= 1'b0;
      ramp_seen_r <= 1'b0;
      sel_r <= 5'h00;
    end else begin
      if (wr40 && avs_writedata_i[mcfg_pkg::LOCK_BIT]) locked_r <= 1'b1;
      if (wr1a) ramp_seen_r <= 1'b1;
      if (wr16) sel_r <= avs_writedata_i[7:3];
    end
  end

  sequence s_fixed_chan;
    ##[1:3] (conv_channel_o == sel_r);
  endsequence

  a_aux_a_copy: assert property (wr16 |-> ##2 aux_output_enable_a_o == $past(avs_writedata_i[0], 2))
    else $error("aux output a does not follow its control bit");
  a_aux_b_copy: assert property (wr16 |-> ##2 aux_output_enable_b_o == $past(avs_writedata_i[1], 2))
    else $error("aux output b does not follow its control bit");
  a_single_copy: assert property (wr16 |-> ##2 single_channel_o == $past(avs_writedata_i[2], 2))
    else $error("single channel output does not follow its control bit");
  a_fixed_chan: assert property (wr16 && avs_writedata_i[2] |-> s_fixed_chan)
    else $error("fixed channel does not match the select field");
  a_div_a_write: assert property (wr18 |=> divider_enable_a_o == $past(avs_writedata_i[7:1]))
    else $error("divider group a does not show the written bits");
  a_div_b_write: assert property (wr19 |=> divider_enable_b_o == $past(avs_writedata_i[7:0]))
    else $error("divider group b does not show the written bits");
  a_locked_hold: assert property (wr18_locked |=> $stable(divider_enable_a_o))
    else $error("locked register changed on a write");
  a_duty_direct: assert property (rst_n_i && !ramp_seen_r && !wr1a |=>
    fan_drive_1_duty_o == $past(fan_drive_1_target_i) && fan_drive_2_duty_o == $past(fan_drive_2_target_i))
    else $error("duty does not follow target with ramp off");
endmodule

bind mcfg_top mcfg_top_sva #(.SLOT_CYCLES(SLOT_CYCLES)) u_sva (.mclk_i, .rst_n_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
  .conv_done_i, .conv_channel_o, .single_channel_o, .aux_output_enable_a_o, .aux_output_enable_b_o,
  .divider_enable_a_o, .divider_enable_b_o, .fan_drive_1_target_i, .fan_drive_2_target_i,
  .fan_drive_1_duty_o, .fan_drive_2_duty_o);

// ==== testbench/test_monitor_config_registers.sv ====
// Purpose: Self-checking bench for the monitor configuration register group.
// Assumes: Ramp slot shortened to 8 cycles; byte lane 0 enabled except in one test.
// Notes: Table rows cover plain writes; channel, ramp, reset, lock and status follow.
`timescale 1ns/1ps
module test_monitor_config_registers;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [1:0] aux; logic [6:0] da;
    logic [7:0] db;} mcfg_row_t;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic conv_done_i = 1'b0;
  logic [7:0] fan_drive_1_target_i = 8'h00;
  logic [7:0] fan_drive_2_target_i = 8'h00;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [4:0] conv_channel_o;
  logic single_channel_o;
  logic aux_output_enable_a_o;
  logic aux_output_enable_b_o;
  logic [6:0] divider_enable_a_o;
  logic [7:0] divider_enable_b_o;
  logic [7:0] fan_drive_1_duty_o;
  logic [7:0] fan_drive_2_duty_o;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  logic [31:0] rd;
  logic [4:0] c0;
  logic [7:0] def_a [4] = '{8'h16, 8'h18, 8'h19, 8'h1a};
  logic [7:0] def_v [4] = '{8'h00, 8'hff, 8'h37, 8'h00};
  logic [4:0] chans [5] = '{5'h00, 5'h01, 5'h08, 5'h10, 5'h11};
  logic [7:0] step [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h18, 8'h30};
  mcfg_row_t rows [9] = '{
    '{8'h16, 8'h03, 8'h03, 2'h3, 7'h7f, 8'h37},
    '{8'h18, 8'h00, 8'h01, 2'h3, 7'h00, 8'h37},
    '{8'h18, 8'haa, 8'hab, 2'h3, 7'h55, 8'h37},
    '{8'h19, 8'hc8, 8'hc8, 2'h3, 7'h55, 8'hc8},
    '{8'h19, 8'h37, 8'h37, 2'h3, 7'h55, 8'h37},
    '{8'h1a, 8'he5, 8'he5, 2'h3, 7'h55, 8'h37},
    '{8'h1a, 8'h00, 8'h00, 2'h3, 7'h55, 8'h37},
    '{8'h16, 8'h02, 8'h02, 2'h2, 7'h55, 8'h37},
    '{8'h17, 8'hff, 8'h00, 2'h2, 7'h55, 8'h37}};

  mcfg_top #(.SLOT_CYCLES(8)) u_dut (.mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .conv_done_i,
    .conv_channel_o, .single_channel_o, .aux_output_enable_a_o, .aux_output_enable_b_o,
    .divider_enable_a_o, .divider_enable_b_o, .fan_drive_1_target_i, .fan_drive_2_target_i,
    .fan_drive_1_duty_o, .fan_drive_2_duty_o);

  always #20 mclk_i = ~mclk_i;

  task end_of_test;
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The request stays up until the edge that samples waitrequest low.
  task bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_write_i <= 1'b1;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask

  task bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
  endtask

  task chk_defaults;
    for (int i = 0; i < 4; i++) begin
      bus_rd(def_a[i], rd);
      chk("reset value", {24'h000000, def_v[i]}, rd);
    end
  endtask

  task pulse_done;
    conv_done_i <= 1'b1;
    @(posedge mclk_i);
    conv_done_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask

  initial begin
    repeat (3) @(posedge mclk_i);
    chk("div_a in reset", 32'h7f, divider_enable_a_o);
    chk("aux in reset", 32'h0, {aux_output_enable_b_o, aux_output_enable_a_o});
    rst_n_i <= 1'b1;
    chk_defaults;
    for (int i = 0; i < 9; i++) begin
      bus_wr(rows[i].a, rows[i].w);
      bus_rd(rows[i].a, rd);
      chk("readback", rows[i].r, rd);
      chk("aux", rows[i].aux, {aux_output_enable_b_o, aux_output_enable_a_o});
      chk("div_a", rows[i].da, divider_enable_a_o);
      chk("div_b", rows[i].db, divider_enable_b_o);
    end
    for (int i = 0; i < 5; i++) begin
      bus_wr(8'h16, {chans[i], 3'b100});
      repeat (4) @(posedge mclk_i);
      chk("single", 32'h1, single_channel_o);
      pulse_done;
      chk("fixed channel", chans[i], conv_channel_o);
    end
    bus_wr(8'h16, 8'h00);
    repeat (3) @(posedge mclk_i);
    c0 = conv_channel_o;
    pulse_done;
    chk("channel moves", 32'h1, conv_channel_o !== c0);
    for (int c = 0; c < 8; c++) begin
      fan_drive_1_target_i <= 8'h00;
      fan_drive_2_target_i <= 8'h00;
      repeat (3) @(posedge mclk_i);
      bus_wr(8'h1a, {c[2:0], c[2:0], 2'b11});
      fan_drive_1_target_i <= 8'hff;
      fan_drive_2_target_i <= 8'hff;
      n = 0;
      while (fan_drive_1_duty_o === 8'h00 && n < 20) begin
        @(posedge mclk_i);
        n++;
      end
      chk("ramp 1 first step", step[c], fan_drive_1_duty_o);
      chk("ramp 2 first step", step[c], fan_drive_2_duty_o);
      repeat (8) @(posedge mclk_i);
      chk("ramp 1 next slot", {step[c], 1'b0}, fan_drive_1_duty_o);
      bus_wr(8'h1a, 8'h00);
      repeat (2) @(posedge mclk_i);
      chk("ramp off jump", 32'hff, fan_drive_1_duty_o);
    end
    bus_wr(8'h40, 8'h02);
    chk_defaults;
    avs_byteenable_i <= 4'he;
    bus_wr(8'h19, 8'h00);
    avs_byteenable_i <= 4'hf;
    bus_rd(8'h19, rd);
    chk("lane 0 off write", 32'h37, rd);
    bus_wr(8'h40, 8'h01);
    bus_wr(8'h18, 8'h00);
    bus_rd(8'h18, rd);
    chk("locked write", 32'hff, rd);
    bus_rd(8'h41, rd);
    chk("lock and violation", 32'h3, rd[25:24]);
    chk("status duties", 32'hffff, rd[23:8]);
    bus_wr(8'h40, 8'h04);
    bus_rd(8'h41, rd);
    chk("violation cleared", 32'h1, rd[25:24]);
    // A power reset in mid-run must drop the lock and turn ramping off.
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk("div_a in second reset", 32'h7f, divider_enable_a_o);
    rst_n_i <= 1'b1;
    fan_drive_1_target_i <= 8'h42;
    fan_drive_2_target_i <= 8'h24;
    bus_wr(8'h18, 8'h00);
    bus_rd(8'h18, rd);
    chk("unlocked after reset", 32'h01, rd);
    chk("duty 1 direct", 32'h42, fan_drive_1_duty_o);
    chk("duty 2 direct", 32'h24, fan_drive_2_duty_o);
    end_of_test;
  end
endmodule
